/* File: hw/rxd_dma_ctrl.sv */
// rxd_dma_ctrl: receive dma mode control, frame commitment and dma result registers.
// assumes mac, buffer and status queue logic on SYS_CLK; only DMA_DONE_PIN is asynchronous.
// Overview of operation
// - exclusive dma mode moves only complete, filter-passing frames to the 16/64K host ring
// - first frame count read commits the space it covers; no writes into it
// - the next frame count read frees the space of the frames it committed
// - auto-switch is active with auto enable set and exclusive clear; on-chip preferred
// - with exclusive set every received frame goes by dma
// - at frame start in auto mode check on-chip room for a maximum frame
// - short of room and failing address filter: discard, stay out of dma
// - short of room and passing filter: switch to dma, drain buffered frames
// - frames leave in arrival order, oldest uncommitted frame first
// - entering dma flushes pending receive events from the status queue
// - only complete frames are moved by auto-switch
// - switch is delayed while a frame is committed to on-chip host processing
// - after each dma frame update start, count and bytes; outside a batch also flag and interrupt
// - a missed frame bumps the missed counter and clears its event reports
// - dma mode stays until events done, zero count read and no transfer
// - batching starts on two good back-to-back frames 9.6 to 52 us apart
// - a batch holds the first good irq, moves up to eight frames, one dma irq
// - batching goes on while frames stay good and close; else raise both irqs
// - outside a batch dma frame flag follows a nonzero frame count; reading events never clears it
`include "rxd_cfg.svh"
module rxd_dma_ctrl #(
   parameter int unsigned GAP_KEEP_TICKS = `RXD_GAP_KEEP_TICKS,
   parameter int unsigned FIFO_DEPTH     = 8
) (
   input  wire logic                   SYS_CLK,
   input  wire logic                   SRST,
   input  wire rxd_pkg::rxd_cfg_t      CFG,
   input  wire logic                   RX_START,
   input  wire logic                   RX_DA_DONE,
   input  wire logic                   RX_DA_PASS,
   input  wire logic                   RX_END,
   input  wire rxd_pkg::rxd_stat_t     RX_STAT,
   input  wire logic                   RX_MISSED,
   input  wire logic [15:0]            ONCHIP_FREE,
   input  wire logic                   ONCHIP_POP,
   input  wire logic                   ONCHIP_COMMITTED,
   input  wire logic                   EVT_PENDING,
   input  wire logic                   DMA_DONE_PIN,
   input  wire logic [`RXD_ADDR_W-1:0] REG_ADDR,
   input  wire logic                   REG_RD,
   output logic [15:0]                 REG_RDATA,
   output logic                        DMA_REQ,
   output logic [`RXD_LEN_W-1:0]       DMA_LEN,
   output logic                        DMA_ACTIVE,
   output logic                        DMA_FRAME_FLAG,
   output logic                        DMA_IRQ,
   output logic                        GOOD_IRQ,
   output logic                        RX_DISCARD,
   output logic                        ISQ_FLUSH,
   output logic                        EVT_CLEAR,
   output logic [15:0]                 MISSED_COUNT
);
   rxd_pkg::rxd_mode_t state;
   rxd_pkg::rxd_mode_t next_state;

   logic [`RXD_LEN_W-1:0] q_data;
   logic                  q_valid;
   logic                  q_full;
   logic                  tick;
   logic                  done_s1;
   logic                  done_s2;
   logic                  done_s3;
   logic                  xfer;
   logic                  low_space;
   logic                  zero_read;
   logic [11:0]           cur_need;
   logic [11:0]           cur_bytes;
   logic [15:0]           wr_ptr;
   logic [15:0]           start_off;
   logic [`RXD_CNT_W-1:0] cnt;
   logic [15:0]           bytes;
   logic [16:0]           acc_space;
   logic [16:0]           committed;
   logic [`RXD_GAP_W-1:0] gap;
   logic                  prev_good;
   logic                  gap_in_win;
   logic                  gap_keep;
   logic                  pend_good;
   logic                  batch_active;
   logic [3:0]            batch_n;

   // cdc: the done pin only reaches logic through done_s2
   always_ff @(posedge SYS_CLK)
   begin
      done_s1 <= DMA_DONE_PIN;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
   end

   rxd_tick_div #(
      .DIV (`RXD_TICK_CYC)
   ) u_tick (
      .clk  (SYS_CLK),
      .srst (SRST),
      .tick (tick)
   );

   wire frame_ok  = RX_END && RX_STAT.good && RX_STAT.da_pass;
   wire q_push    = RX_END && RX_STAT.da_pass;
   wire dma_on    = (state == rxd_pkg::MODE_DMA);
   wire auto_only = CFG.auto_switch_enable && !CFG.exclusive;
   wire done_edge = done_s2 && !done_s3 && xfer;
   wire frame_done = done_edge;

   wire [16:0] host_size = CFG.buf64 ? `RXD_HOST_64K : `RXD_HOST_16K;
   wire [11:0] raw_bytes = {1'b0, q_data} + `RXD_HDR_BYTES;
   wire [11:0] need      = (raw_bytes + `RXD_ALIGN_ADD) & 12'hFFC;
   wire [17:0] used      = {6'h00, need} + {1'b0, committed};
   wire        room      = used <= {1'b0, host_size};
   wire        start     = dma_on && q_valid && !xfer && room;
   wire        q_pop     = start || (!dma_on && ONCHIP_POP);

   // one decode for every mode
   wire rd_start = REG_RD && (REG_ADDR == `RXD_REG_START);
   wire rd_cnt   = REG_RD && (REG_ADDR == `RXD_REG_COUNT);
   wire rd_bytes = REG_RD && (REG_ADDR == `RXD_REG_BYTES);

   wire short_room = ONCHIP_FREE < `RXD_MAX_FRAME;
   wire da_fail    = low_space && RX_DA_DONE && !RX_DA_PASS;
   wire da_switch  = low_space && RX_DA_DONE && RX_DA_PASS;

   wire batch_start = CFG.batch_transfer_enable && !batch_active
                      && frame_ok && prev_good && gap_in_win;
   wire batch_bad   = batch_active && RX_END
                      && !(RX_STAT.good && RX_STAT.da_pass && gap_keep);
   wire batch_idle  = batch_active && !xfer && !q_valid
                      && (gap >= `RXD_GAP_W'(GAP_KEEP_TICKS));
   wire batch_exit  = batch_bad || batch_idle;
   wire batch_full  = batch_active && frame_done
                      && (batch_n == `RXD_BATCH_MAX - 4'h1);
   wire batch_end   = batch_full || batch_exit;

   wire [`RXD_CNT_W-1:0] cnt_inc = frame_done ? `RXD_CNT_W'(1) : '0;
   wire [`RXD_CNT_W-1:0] next_count = rd_cnt ? cnt_inc : cnt + cnt_inc;
   wire [15:0] add_bytes  = frame_done ? {4'h0, cur_bytes} : 16'h0000;
   wire [15:0] next_bytes = rd_bytes ? add_bytes : bytes + add_bytes;
   wire [16:0] add_space  = frame_done ? {5'h00, cur_need} : 17'h00000;
   wire next_flag = (next_count != '0)
                    && (!batch_active || batch_end || DMA_FRAME_FLAG);

   wire exit_ok = !CFG.exclusive && !batch_active && !EVT_PENDING
                  && zero_read && !xfer;

   always_comb
   begin
      next_state = state;
      unique case (state)
         rxd_pkg::MODE_ONCHIP:
         begin
            if (CFG.exclusive || batch_start)
               next_state = rxd_pkg::MODE_DMA;
            else if (da_switch && auto_only)
               next_state = ONCHIP_COMMITTED ? rxd_pkg::MODE_WAIT : rxd_pkg::MODE_DMA;
         end
         rxd_pkg::MODE_WAIT:
         begin
            if (CFG.exclusive || !ONCHIP_COMMITTED)
               next_state = rxd_pkg::MODE_DMA;
         end
         rxd_pkg::MODE_DMA:
         begin
            if (exit_ok)
               next_state = rxd_pkg::MODE_ONCHIP;
         end
         default:
            next_state = rxd_pkg::MODE_ONCHIP;
      endcase
   end

   rxd_len_fifo #(
      .W     (`RXD_LEN_W),
      .DEPTH (FIFO_DEPTH),
      .AW    ($clog2(FIFO_DEPTH))
   ) u_fifo (
      .clk   (SYS_CLK),
      .srst  (SRST),
      .push  (q_push),
      .wdata (RX_STAT.len),
      .pop   (q_pop),
      .rdata (q_data),
      .valid (q_valid),
      .full  (q_full)
   );

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         state      <= rxd_pkg::MODE_ONCHIP;
         low_space  <= 1'b0;
         RX_DISCARD <= 1'b0;
         ISQ_FLUSH  <= 1'b0;
         DMA_ACTIVE <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         low_space  <= (RX_START && auto_only && short_room) || (low_space && !RX_DA_DONE);
         RX_DISCARD <= da_fail && (state == rxd_pkg::MODE_ONCHIP);
         ISQ_FLUSH  <= !dma_on && (next_state == rxd_pkg::MODE_DMA);
         DMA_ACTIVE <= next_state == rxd_pkg::MODE_DMA;
      end
   end

   // transfer of the oldest held frame to the host ring
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         xfer      <= 1'b0;
         DMA_REQ   <= 1'b0;
         DMA_LEN   <= '0;
         cur_need  <= 12'h000;
         cur_bytes <= 12'h000;
         wr_ptr    <= 16'h0000;
         start_off <= 16'h0000;
      end
      else if (start)
      begin
         xfer      <= 1'b1;
         DMA_REQ   <= 1'b1;
         DMA_LEN   <= q_data;
         cur_need  <= need;
         cur_bytes <= raw_bytes;
      end
      else if (frame_done)
      begin
         xfer      <= 1'b0;
         DMA_REQ   <= 1'b0;
         start_off <= wr_ptr;
         wr_ptr    <= 16'((17'(wr_ptr) + {5'h00, cur_need}) & (host_size - 17'h00001));
      end
   end

   // result registers, commitment and flag; a completion wins over a clearing read
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         cnt            <= '0;
         bytes          <= 16'h0000;
         acc_space      <= 17'h00000;
         committed      <= 17'h00000;
         zero_read      <= 1'b0;
         DMA_FRAME_FLAG <= 1'b0;
      end
      else
      begin
         cnt            <= next_count;
         bytes          <= next_bytes;
         DMA_FRAME_FLAG <= next_flag;
         if (rd_cnt)
         begin
            committed <= acc_space;
            acc_space <= add_space;
            zero_read <= (cnt == '0) && !frame_done;
         end
         else
         begin
            acc_space <= acc_space + add_space;
            zero_read <= zero_read && !frame_done;
         end
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         REG_RDATA <= 16'h0000;
      else if (rd_start)
         REG_RDATA <= start_off;
      else if (rd_cnt)
         REG_RDATA <= {4'h0, cnt};
      else if (rd_bytes)
         REG_RDATA <= bytes;
      else if (REG_RD)
         REG_RDATA <= 16'h0000;
   end

   // gap timer in 100 ns ticks since the end of the last frame
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         gap        <= '1;
         prev_good  <= 1'b0;
         gap_in_win <= 1'b0;
         gap_keep   <= 1'b0;
      end
      else
      begin
         if (RX_END)
            gap <= '0;
         else if (tick && gap != '1)
            gap <= gap + `RXD_GAP_W'(1);
         if (RX_END)
            prev_good <= RX_STAT.good && RX_STAT.da_pass;
         if (RX_START)
         begin
            gap_in_win <= (gap >= `RXD_GAP_W'(`RXD_GAP_MIN_TICKS))
                          && (gap <= `RXD_GAP_W'(`RXD_GAP_MAX_TICKS));
            gap_keep   <= gap < `RXD_GAP_W'(GAP_KEEP_TICKS);
         end
      end
   end

   // batching; the first good irq is held back until it is clear no batch follows
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         batch_active <= 1'b0;
         batch_n      <= 4'h0;
         pend_good    <= 1'b0;
         GOOD_IRQ     <= 1'b0;
         DMA_IRQ      <= 1'b0;
      end
      else
      begin
         if (batch_start)
            batch_active <= 1'b1;
         else if (batch_exit)
            batch_active <= 1'b0;
         if (!batch_active || batch_end)
            batch_n <= 4'h0;
         else if (frame_done)
            batch_n <= batch_n + 4'h1;
         pend_good <= CFG.batch_transfer_enable && !batch_active && !batch_start
                      && (frame_ok || (pend_good && gap <= `RXD_GAP_W'(`RXD_GAP_MAX_TICKS)));
         GOOD_IRQ  <= CFG.good_frame_irq_en
                      && (batch_exit
                          || (pend_good && gap > `RXD_GAP_W'(`RXD_GAP_MAX_TICKS))
                          || (frame_ok && !dma_on && !CFG.batch_transfer_enable));
         DMA_IRQ   <= CFG.dma_frame_irq_en
                      && (batch_active ? batch_end : frame_done);
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         MISSED_COUNT <= 16'h0000;
         EVT_CLEAR    <= 1'b0;
      end
      else
      begin
         MISSED_COUNT <= MISSED_COUNT + {15'h0000, RX_MISSED};
         EVT_CLEAR    <= RX_MISSED;
      end
   end

   a_start_needs_frame: assert property (@(posedge SYS_CLK) disable iff (SRST)
      $rose(DMA_REQ) |-> $past(q_valid) && $past(dma_on))
      else $error("dma started without a held frame");
   a_commit_room: assert property (@(posedge SYS_CLK) disable iff (SRST)
      $rose(DMA_REQ) |-> ({6'h00, cur_need} + {1'b0, $past(committed)}) <= {1'b0, host_size})
      else $error("dma write into committed space");
   a_read_frees: assert property (@(posedge SYS_CLK) disable iff (SRST)
      rd_cnt |=> committed == $past(acc_space))
      else $error("count read did not move commitment");
   a_exclusive_dma: assert property (@(posedge SYS_CLK) disable iff (SRST)
      CFG.exclusive |=> state == rxd_pkg::MODE_DMA)
      else $error("exclusive mode not in dma");
   a_da_fail_stays: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (da_fail && state == rxd_pkg::MODE_ONCHIP && !CFG.exclusive && !batch_start)
      |=> RX_DISCARD && state == rxd_pkg::MODE_ONCHIP)
      else $error("filter miss did not discard");
   a_flush_entry: assert property (@(posedge SYS_CLK) disable iff (SRST)
      $rose(DMA_ACTIVE) |-> ISQ_FLUSH)
      else $error("no queue flush on dma entry");
   a_wait_commit: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (state == rxd_pkg::MODE_WAIT && ONCHIP_COMMITTED && !CFG.exclusive)
      |=> state == rxd_pkg::MODE_WAIT)
      else $error("switch while frame committed");
   a_done_updates: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (frame_done && !rd_cnt) |=> cnt == $past(cnt) + 1'b1 && start_off == $past(wr_ptr))
      else $error("dma results not updated");
   a_missed_bump: assert property (@(posedge SYS_CLK) disable iff (SRST)
      RX_MISSED |=> EVT_CLEAR && MISSED_COUNT == $past(MISSED_COUNT) + 16'h0001)
      else $error("missed frame not counted");
   a_dma_holds: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (dma_on && (EVT_PENDING || xfer)) |=> dma_on)
      else $error("left dma too early");
   a_flag_count: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (!batch_active && !$past(batch_active)) |-> DMA_FRAME_FLAG == (cnt != '0))
      else $error("frame flag does not follow count");
endmodule : rxd_dma_ctrl

/* File: hw/rxd_cfg.svh */
// rxd_cfg.svh: offsets, field sizes and timing counts of the receive dma mode control.
// assumes a 250 MHz system clock; included by bare name.
`ifndef RXD_CFG_SVH
`define RXD_CFG_SVH
`define RXD_ADDR_W          16
`define RXD_REG_START       16'h0026
`define RXD_REG_COUNT       16'h0028
`define RXD_REG_BYTES       16'h002A
`define RXD_CNT_W           12
`define RXD_LEN_W           11
`define RXD_HOST_16K        17'h04000
`define RXD_HOST_64K        17'h10000
`define RXD_MAX_FRAME       16'h05EE
`define RXD_HDR_BYTES       12'h004
`define RXD_ALIGN_ADD       12'h003
`define RXD_BATCH_MAX       4'h8
`define RXD_CLK_PERIOD_NS   4
`define RXD_TICK_NS         100
`define RXD_TICK_CYC        (`RXD_TICK_NS / `RXD_CLK_PERIOD_NS)
`define RXD_GAP_MIN_NS      9600
`define RXD_GAP_MAX_NS      52000
`define RXD_GAP_KEEP_MS     52
`define RXD_GAP_MIN_TICKS   ((`RXD_GAP_MIN_NS + `RXD_TICK_NS - 1) / `RXD_TICK_NS)
`define RXD_GAP_MAX_TICKS   (`RXD_GAP_MAX_NS / `RXD_TICK_NS)
`define RXD_GAP_KEEP_TICKS  ((`RXD_GAP_KEEP_MS * 1000000) / `RXD_TICK_NS)
`define RXD_GAP_W           20
`endif

/* File: hw/rxd_pkg.sv */
// rxd_pkg: types shared by the receive dma mode control.
// assumes rxd_cfg.svh is on the include path.
`include "rxd_cfg.svh"
package rxd_pkg;
   typedef struct packed {
      logic exclusive;
      logic auto_switch_enable;
      logic batch_transfer_enable;
      logic dma_frame_irq_en;
      logic good_frame_irq_en;
      logic buf64;
   } rxd_cfg_t;

   typedef struct packed {
      logic                  good;
      logic                  da_pass;
      logic [`RXD_LEN_W-1:0] len;
   } rxd_stat_t;

   typedef enum logic [1:0] {
      MODE_ONCHIP = 2'b00,
      MODE_WAIT   = 2'b01,
      MODE_DMA    = 2'b10
   } rxd_mode_t;
endpackage : rxd_pkg

/* File: hw/rxd_tick_div.sv */
// rxd_tick_div: one-cycle enable every DIV clocks.
// assumes one clock domain with synchronous reset.
module rxd_tick_div #(
   parameter int unsigned DIV = 25
) (
   input  wire logic clk,
   input  wire logic srst,
   output logic      tick
);
   logic [7:0] cnt;
   wire        wrap = (cnt == 8'(DIV - 1));

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt  <= 8'h00;
         tick <= 1'b0;
      end
      else
      begin
         cnt  <= wrap ? 8'h00 : cnt + 8'h01;
         tick <= wrap;
      end
   end
endmodule : rxd_tick_div

/* File: hw/rxd_len_fifo.sv */
// rxd_len_fifo: length queue of complete frames held on chip, oldest first.
// assumes pops are at least two cycles apart; read data and valid lag one cycle.
module rxd_len_fifo #(
   parameter int unsigned W     = 11,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned AW    = 3
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         push,
   input  wire logic [W-1:0] wdata,
   input  wire logic         pop,
   output logic [W-1:0]      rdata,
   output logic              valid,
   output logic              full
);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   cnt;
   wire           do_push = push && !full;
   wire           do_pop  = pop && valid;

   always_ff @(posedge clk)
   begin
      if (do_push)
         mem[wp] <= wdata;
      rdata <= mem[rp];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wp    <= '0;
         rp    <= '0;
         cnt   <= '0;
         valid <= 1'b0;
         full  <= 1'b0;
      end
      else
      begin
         wp    <= do_push ? wp + AW'(1) : wp;
         rp    <= do_pop ? rp + AW'(1) : rp;
         cnt   <= cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
         valid <= (cnt != '0) && !do_pop;
         full  <= (cnt + (AW+1)'(do_push) - (AW+1)'(do_pop)) == (AW+1)'(DEPTH);
      end
   end
endmodule : rxd_len_fifo

/* File: dv/rxd_host_dma.sv */
// rxd_host_dma: host dma controller and driver ring pointer, behavioural.
// assumes the request and its length hold until the done edge is taken.
module rxd_host_dma (
   input  wire logic        clk,
   input  wire logic        req,
   input  wire logic [10:0] len,
   output logic             done_pin,
   output logic [15:0]      ring_ptr
);
   timeunit 1ns;
   timeprecision 1ps;
   int   wait_cyc;
   logic slow;
   initial
   begin
      done_pin = 1'b0;
      ring_ptr = 16'h0000;
      slow = 1'b0;
      forever
      begin
         @(posedge clk);
         if (req === 1'b1 && done_pin === 1'b0)
         begin
            // alternate prompt and slow channels to vary the transfer time
            wait_cyc = slow ? 40 : 2;
            slow = ~slow;
            repeat (wait_cyc) @(posedge clk);
            done_pin <= 1'b1;
            ring_ptr <= (ring_ptr + 16'(len) + 16'h0007) & 16'hFFFC;
            while (req === 1'b1) @(posedge clk);
            done_pin <= 1'b0;
         end
      end
   end
endmodule : rxd_host_dma

/* File: dv/rx_dma_mode_control_tb_top.sv */
// rx_dma_mode_control_tb_top: self-checking bench of the receive dma mode control.
// assumes rxd_host_dma answers dma requests; register reads are checked from a queue.
`include "rxd_cfg.svh"
module rx_dma_mode_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic              sys_clk = 1'b0, srst = 1'b1, rd = 1'b0, rd_pend = 1'b0;
   logic              rx_start = 1'b0, rx_da_done = 1'b0, rx_da_pass = 1'b0, rx_end = 1'b0, rx_missed = 1'b0;
   logic              pop = 1'b0, commit = 1'b0, evt = 1'b0;
   int                n_good = 0;
   rxd_pkg::rxd_cfg_t cfg = '0;
   rxd_pkg::rxd_stat_t stat = '0;
   logic [15:0]       free = 16'hFFFF, addr = 16'h0000, rdata, missed, ring_ptr;
   logic [10:0]       dma_len, l1, l2;
   logic              dma_req, dma_active, flag, dma_irq, good_irq, discard, flush, evt_clr, done_pin;
   logic [31:0]       seed = 32'h76B83053;
   logic [15:0]       exp_q[$];
   int                errors = 0, cmp_count = 0, cyc = 0, n_irq = 0, n_flush = 0, n_clr = 0, n_disc = 0, f0;

   rxd_dma_ctrl #(.GAP_KEEP_TICKS(2000), .FIFO_DEPTH(8)) u_rxd_dma_ctrl (
      .SYS_CLK(sys_clk), .SRST(srst), .CFG(cfg), .RX_START(rx_start), .RX_DA_DONE(rx_da_done),
      .RX_DA_PASS(rx_da_pass), .RX_END(rx_end), .RX_STAT(stat), .RX_MISSED(rx_missed),
      .ONCHIP_FREE(free), .ONCHIP_POP(pop), .ONCHIP_COMMITTED(commit), .EVT_PENDING(evt),
      .DMA_DONE_PIN(done_pin), .REG_ADDR(addr), .REG_RD(rd), .REG_RDATA(rdata), .DMA_REQ(dma_req),
      .DMA_LEN(dma_len), .DMA_ACTIVE(dma_active), .DMA_FRAME_FLAG(flag), .DMA_IRQ(dma_irq),
      .GOOD_IRQ(good_irq), .RX_DISCARD(discard), .ISQ_FLUSH(flush), .EVT_CLEAR(evt_clr),
      .MISSED_COUNT(missed));
   rxd_host_dma u_rxd_host_dma (.clk(sys_clk), .req(dma_req), .len(dma_len), .done_pin(done_pin),
      .ring_ptr(ring_ptr));

   always #2 sys_clk = ~sys_clk;

   task automatic close_out();
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // the read is noted before it is issued; the monitor below pops it
   task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(negedge sys_clk);
      addr = a;
      rd = 1'b1;
      @(negedge sys_clk);
      rd = 1'b0;
   endtask : rd_reg

   task automatic frame(input logic [10:0] l, input logic p);
      @(negedge sys_clk);
      rx_end = 1'b1;
      stat = '{good: 1'b1, da_pass: p, len: l};
      @(negedge sys_clk);
      rx_end = 1'b0;
   endtask : frame

   task automatic arrive(input logic p);
      @(negedge sys_clk);
      rx_start = 1'b1;
      @(negedge sys_clk);
      rx_start = 1'b0;
      rx_da_done = 1'b1;
      rx_da_pass = p;
      @(negedge sys_clk);
      rx_da_done = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask : arrive

   task automatic wait_irq(input int k);
      for (int i = 0; i < 400 && n_irq < k; i++) @(negedge sys_clk);
   endtask : wait_irq

   always @(posedge sys_clk)
   begin
      rd_pend <= rd;
      n_irq <= n_irq + int'(dma_irq === 1'b1);
      n_flush <= n_flush + int'(flush === 1'b1);
      n_clr <= n_clr + int'(evt_clr === 1'b1);
      n_disc <= n_disc + int'(discard === 1'b1);
      n_good <= n_good + int'(good_irq === 1'b1);
      cyc <= cyc + 1;
      // whole run is a few thousand cycles, mostly the batch gap; this ceiling only cuts a hang
      if (cyc == 20000)
      begin
         errors++;
         close_out();
      end
   end

   always @(negedge sys_clk)
      if (rd_pend === 1'b1)
         chk("REG_RDATA", exp_q.pop_front(), rdata);

   initial
   begin
      cfg = '{exclusive: 1'b1, auto_switch_enable: 1'b1, batch_transfer_enable: 1'b0,
              dma_frame_irq_en: 1'b1, good_frame_irq_en: 1'b0, buf64: 1'b1};
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("DMA_ACTIVE", 16'h0001, 16'(dma_active));
      seed = lfsr(seed);
      l1 = 11'h040 + 11'(seed[9:0]);
      seed = lfsr(seed);
      l2 = 11'h040 + 11'(seed[9:0]);
      frame(l1, 1'b1);
      wait_irq(1);
      frame(l2, 1'b1);
      wait_irq(2);
      frame(l2, 1'b0);
      repeat (60) @(negedge sys_clk);
      chk("DMA_IRQ", 16'h0002, 16'(n_irq));
      chk("DMA_FRAME_FLAG", 16'h0001, 16'(flag));
      chk("DMA_REQ", 16'h0000, 16'(dma_req));
      chk("DMA_LEN", 16'(l2), 16'(dma_len));
      chk("ring_ptr", ((16'(l1) + 16'h0007) & 16'hFFFC) + ((16'(l2) + 16'h0007) & 16'hFFFC), ring_ptr);
      rd_reg(`RXD_REG_START, (16'(l1) + 16'h0007) & 16'hFFFC);
      rd_reg(`RXD_REG_COUNT, 16'h0002);
      rd_reg(`RXD_REG_BYTES, 16'(l1) + 16'(l2) + 16'h0008);
      rd_reg(`RXD_REG_COUNT, 16'h0000);
      rd_reg(16'h0040, 16'h0000);
      chk("DMA_FRAME_FLAG", 16'h0000, 16'(flag));
      @(negedge sys_clk);
      rx_missed = 1'b1;
      @(negedge sys_clk);
      rx_missed = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("MISSED_COUNT", 16'h0001, missed);
      chk("EVT_CLEAR", 16'h0001, 16'(n_clr));
      // second reset, now auto-switch alone; two frames buffered on chip, the host takes one
      srst = 1'b1;
      cfg.exclusive = 1'b0;
      cfg.good_frame_irq_en = 1'b1;
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      free = 16'h05EE;
      arrive(1'b1);
      chk("DMA_ACTIVE", 16'h0000, 16'(dma_active));
      frame(l1, 1'b1);
      frame(l2, 1'b1);
      pop = 1'b1;
      @(negedge sys_clk);
      pop = 1'b0;
      free = 16'h0100;
      arrive(1'b0);
      chk("RX_DISCARD", 16'h0001, 16'(n_disc));
      chk("DMA_ACTIVE", 16'h0000, 16'(dma_active));
      chk("GOOD_IRQ", 16'h0002, 16'(n_good));
      f0 = n_flush;
      commit = 1'b1;
      evt = 1'b1;
      arrive(1'b1);
      chk("DMA_ACTIVE", 16'h0000, 16'(dma_active));
      commit = 1'b0;
      wait_irq(3);
      chk("DMA_ACTIVE", 16'h0001, 16'(dma_active));
      chk("ISQ_FLUSH", 16'(f0 + 1), 16'(n_flush));
      chk("DMA_LEN", 16'(l2), 16'(dma_len));
      rd_reg(`RXD_REG_COUNT, 16'h0001);
      rd_reg(`RXD_REG_COUNT, 16'h0000);
      chk("DMA_ACTIVE", 16'h0001, 16'(dma_active));
      evt = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("DMA_ACTIVE", 16'h0000, 16'(dma_active));
      // third reset: batching on top of auto-switch with the good frame irq on
      srst = 1'b1;
      cfg.batch_transfer_enable = 1'b1;
      free = 16'hFFFF;
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      arrive(1'b1);
      frame(l1, 1'b1);
      repeat (3000) @(negedge sys_clk);
      arrive(1'b1);
      frame(l2, 1'b1);
      repeat (300) @(negedge sys_clk);
      chk("DMA_ACTIVE", 16'h0001, 16'(dma_active));
      chk("DMA_IRQ", 16'h0003, 16'(n_irq));
      chk("GOOD_IRQ", 16'h0002, 16'(n_good));
      chk("DMA_FRAME_FLAG", 16'h0000, 16'(flag));
      frame(l1, 1'b0);
      repeat (2) @(negedge sys_clk);
      chk("DMA_IRQ", 16'h0004, 16'(n_irq));
      chk("GOOD_IRQ", 16'h0003, 16'(n_good));
      chk("DMA_FRAME_FLAG", 16'h0001, 16'(flag));
      rd_reg(`RXD_REG_COUNT, 16'h0002);
      close_out();
   end
endmodule : rx_dma_mode_control_tb_top
